// ---- rtl/lpa_regs.vh ----
// register offsets, field positions and sizes of the phy access and fifo status block
`ifndef LPA_REGS_VH
`define LPA_REGS_VH
`define LPA_OFF_PHY_ACCESS 8'h24
`define LPA_OFF_ATX_STATUS 8'h30
`define LPA_OFF_ITX_STATUS 8'h34
`define LPA_OFF_RX_STATUS 8'h3C
`define LPA_OFF_RAM_DATA 8'h80
`define LPA_RESET_VALUE 32'h0000_0000
`define LPA_FIFO_DEPTH 10'h200
`define LPA_FIFO_AW 9
`define LPA_WORD_W 33
`define LPA_CTRL_BIT 32
// phy access fields, bit 31 is the msb of the bus word (little-endian numbering)
`define LPA_PHY_RD 31
`define LPA_PHY_WR 30
// atx status fields
`define LPA_ATX_FULL 31
`define LPA_ATX_EMPTY 30
`define LPA_ATX_CONTROL_ERROR_FLAG 29
`define LPA_ATX_ADDRESS_CLEAR 28
`define LPA_ATX_CONTROL 27
`define LPA_ATX_MEMORY_TEST_MODE 26
`endif

// ---- rtl/lpa_phy_fifo_regs.v ----
// host register bank for phy register access and fifo status of the link controller
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lpa_regs.vh"
module lpa_phy_fifo_regs (
   input wire mclk,
   input wire sys_rst,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   output reg phyReqValid,
   output reg phyReqWrite,
   output reg [3:0] phyReqAddr,
   output reg [7:0] phyReqData,
   input wire phyReqReady,
   input wire phyInfoValid,
   input wire [3:0] phyInfoAddr,
   input wire [7:0] phyInfoData,
   output reg phyInfoReceivedIrq,
   input wire irqClear,
   input wire asyncFull,
   input wire asyncEmpty,
   input wire [8:0] asyncFreeSpace,
   input wire isoFull,
   input wire isoEmpty,
   input wire [8:0] isoFreeSpace,
   input wire rxEmpty,
   input wire rxTokenAtHead,
   input wire rxLastBlock,
   input wire [9:0] rxTotalQuadlets,
   input wire [8:0] rxNextBlockQuadlets,
   input wire [8:0] asyncAllocSize,
   input wire [8:0] isoAllocSize,
   input wire triggerSplitEnable,
   input wire flushBadPackets,
   input wire asyncFifoWriteReq,
   input wire isoFifoWriteReq,
   output wire asyncFifoWriteEn,
   output wire isoFifoWriteEn,
   output reg fifoDisabled
);
   ////////////////////////////////////////////////////////////////////////////
   reg phyReadReq_reg;
   reg phyWriteReq_reg;
   reg [3:0] phyTargetAddr_reg;
   reg [7:0] phyWriteByte_reg;
   reg [3:0] phyReturnedAddr_reg;
   reg [7:0] phyReturnedByte_reg;
   reg control_error_flag_reg;
   reg address_clear_reg;
   reg testControl_reg;
   reg [8:0] testAddr_reg;
   reg [32:0] ram [0:511];
   reg phyBusy_reg;
   wire wrEn;
   wire rdEn;
   wire ramAccess;
   wire [8:0] accAddr;
   wire [9:0] rxCapacity;
   wire rxLastShown;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wrEn = psel & penable & pwrite;
   assign rdEn = psel & penable & ~pwrite;
   assign ramAccess = psel & penable & fifoDisabled & (paddr == `LPA_OFF_RAM_DATA);
   assign accAddr = address_clear_reg ? 9'h000 : testAddr_reg;
   assign asyncFifoWriteEn = asyncFifoWriteReq & ~asyncFull & ~fifoDisabled;
   assign isoFifoWriteEn = isoFifoWriteReq & ~isoFull & ~fifoDisabled;
   // the 10-bit difference is kept in range by the host's allocation limit
   wire [9:0] capWide = `LPA_FIFO_DEPTH - {1'b0, asyncAllocSize} - {1'b0, isoAllocSize};
   assign rxCapacity = capWide;
   assign rxLastShown = (~triggerSplitEnable | flushBadPackets) ? 1'b1 : rxLastBlock;
   ////////////////////////////////////////////////////////////////////////////
   // phy access register and request launch
   always @(posedge mclk) begin
      if (sys_rst) begin
         phyReadReq_reg <= 1'b0;
         phyWriteReq_reg <= 1'b0;
         phyTargetAddr_reg <= 4'h0;
         phyWriteByte_reg <= 8'h00;
         phyReturnedAddr_reg <= 4'h0;
         phyReturnedByte_reg <= 8'h00;
         phyReqValid <= 1'b0;
         phyReqWrite <= 1'b0;
         phyReqAddr <= 4'h0;
         phyReqData <= 8'h00;
         phyBusy_reg <= 1'b0;
         phyInfoReceivedIrq <= 1'b0;
      end else begin
         if (phyReqValid && phyReqReady) begin
            phyReqValid <= 1'b0;
            phyBusy_reg <= 1'b0;
            if (phyReqWrite) begin
               phyWriteReq_reg <= 1'b0;
            end else begin
               phyReadReq_reg <= 1'b0;
            end
         end else if (!phyBusy_reg && (phyReadReq_reg || phyWriteReq_reg)) begin
            // read wins when both are set; write goes out next
            phyReqValid <= 1'b1;
            phyBusy_reg <= 1'b1;
            phyReqWrite <= ~phyReadReq_reg;
            phyReqAddr <= phyTargetAddr_reg;
            phyReqData <= phyWriteByte_reg;
         end
         // host write comes last so a fresh request wins over the self-clear
         if (wrEn && paddr == `LPA_OFF_PHY_ACCESS) begin
            phyReadReq_reg <= pwdata[`LPA_PHY_RD];
            phyWriteReq_reg <= pwdata[`LPA_PHY_WR];
            phyTargetAddr_reg <= pwdata[27:24];
            phyWriteByte_reg <= pwdata[23:16];
         end
         if (phyInfoValid) begin
            phyReturnedAddr_reg <= phyInfoAddr;
            phyReturnedByte_reg <= phyInfoData;
         end
         // set wins over clear
         if (phyInfoValid) begin
            phyInfoReceivedIrq <= 1'b1;
         end else if (irqClear) begin
            phyInfoReceivedIrq <= 1'b0;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // ram test control
   always @(posedge mclk) begin
      if (sys_rst) begin
         control_error_flag_reg <= 1'b0;
         address_clear_reg <= 1'b0;
         testControl_reg <= 1'b0;
         fifoDisabled <= 1'b0;
         testAddr_reg <= 9'h000;
      end else begin
         if (ramAccess) begin
            testAddr_reg <= accAddr + 9'h001; // wraps after 511
            address_clear_reg <= 1'b0;
            if (!pwrite && ram[accAddr][`LPA_CTRL_BIT] != testControl_reg) begin
               control_error_flag_reg <= 1'b1;
            end else if (address_clear_reg) begin
               control_error_flag_reg <= 1'b0;
            end
         end
         if (wrEn && paddr == `LPA_OFF_ATX_STATUS) begin
            testControl_reg <= pwdata[`LPA_ATX_CONTROL];
            fifoDisabled <= pwdata[`LPA_ATX_MEMORY_TEST_MODE];
            if (pwdata[`LPA_ATX_ADDRESS_CLEAR]) begin
               address_clear_reg <= 1'b1;
            end
            if (pwdata[`LPA_ATX_ADDRESS_CLEAR] || !pwdata[`LPA_ATX_MEMORY_TEST_MODE]) begin
               control_error_flag_reg <= 1'b0;
            end
         end
      end
   end
   // storage has no reset; contents are only defined once written
   always @(posedge mclk) begin
      if (ramAccess && pwrite) begin
         ram[accAddr] <= {testControl_reg, pwdata};
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // read mux, data registered in the setup cycle
   always @(posedge mclk) begin
      if (sys_rst) begin
         prdata <= `LPA_RESET_VALUE;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            `LPA_OFF_PHY_ACCESS: prdata <= {phyReadReq_reg, phyWriteReq_reg, 2'b00, phyTargetAddr_reg,
                                            phyWriteByte_reg, 4'h0, phyReturnedAddr_reg, phyReturnedByte_reg};
            `LPA_OFF_ATX_STATUS: prdata <= {asyncFull, asyncEmpty, control_error_flag_reg, address_clear_reg, testControl_reg,
                                            fifoDisabled, testAddr_reg, 8'h00, asyncFreeSpace};
            `LPA_OFF_ITX_STATUS: prdata <= {isoFull, isoEmpty, 21'h00_0000, isoFreeSpace};
            `LPA_OFF_RX_STATUS: prdata <= {rxEmpty, rxTokenAtHead, rxLastShown, rxTotalQuadlets,
                                           rxCapacity, rxNextBlockQuadlets};
            `LPA_OFF_RAM_DATA: prdata <= fifoDisabled ? ram[accAddr][31:0] : 32'h0000_0000;
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule // lpa_phy_fifo_regs
`default_nettype wire

// ---- sim/lpa_regs_asserts.sv ----
// checker for the phy access and fifo status register bank
`timescale 1ns/1ps
`default_nettype none
module lpa_regs_asserts (
   input wire mclk, sys_rst, psel, penable, pwrite, phyReqValid, phyReqWrite, phyReqReady,
   input wire phyInfoValid, phyInfoReceivedIrq, irqClear, asyncFull, isoFull, fifoDisabled,
   input wire asyncFifoWriteReq, asyncFifoWriteEn, isoFifoWriteEn,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] phyReqAddr
);
default clocking @(posedge mclk); endclocking
default disable iff (sys_rst);
sequence acc(a);
   psel && penable && pwrite && paddr == a;
endsequence
rd_go_a: assert property (acc(8'h24) ##0 (pwdata[31] && !phyReqValid) |=> ##1 (phyReqValid && !phyReqWrite))
   else $error("phy read not issued");
wr_go_a: assert property (acc(8'h24) ##0 (pwdata[30] && !pwdata[31] && !phyReqValid)
   |=> ##1 (phyReqValid && phyReqWrite && phyReqAddr == $past(pwdata[27:24], 2))) else $error("phy write not issued");
req_hold_a: assert property (phyReqValid && !phyReqReady |=> phyReqValid && $stable(phyReqAddr))
   else $error("phy request dropped");
irq_set_a: assert property (phyInfoValid |=> phyInfoReceivedIrq) else $error("irq not set");
irq_hold_a: assert property (phyInfoReceivedIrq && !irqClear |=> phyInfoReceivedIrq) else $error("irq lost");
atx_gate_a: assert property (asyncFifoWriteReq |-> asyncFifoWriteEn == !(asyncFull || fifoDisabled))
   else $error("async write gate");
itx_gate_a: assert property (isoFull || fifoDisabled |-> !isoFifoWriteEn) else $error("iso write gate");
test_mode_a: assert property (acc(8'h30) |=> fifoDisabled == $past(pwdata[26])) else $error("test mode");
endmodule // lpa_regs_asserts
bind lpa_phy_fifo_regs lpa_regs_asserts u_chk (.*);
`default_nettype wire

// ---- sim/lpa_phy_model.sv ----
// behavioural phy chip answering register requests
`timescale 1ns/1ps
`default_nettype none
module lpa_phy_model (
   input wire logic mclk,
   input wire logic [3:0] waitCycles,
   input wire logic phyReqValid,
   input wire logic phyReqWrite,
   input wire logic [3:0] phyReqAddr,
   input wire logic [7:0] phyReqData,
   output logic phyReqReady = 1'b0,
   output logic phyInfoValid = 1'b0,
   output logic [3:0] phyInfoAddr = 4'h0,
   output logic [7:0] phyInfoData = 8'h00
);
logic [7:0] regs [16];
logic [3:0] cnt = 4'h0;
always @(posedge mclk) begin
   phyInfoValid <= 1'b0;
   // idle lines toggle so a stale value is never mistaken for data
   phyInfoAddr <= ~phyInfoAddr;
   phyInfoData <= ~phyInfoData;
   if (phyReqReady) begin
      phyReqReady <= 1'b0;
      cnt <= 4'h0;
      if (phyReqWrite) regs[phyReqAddr] <= phyReqData;
      else begin
         phyInfoValid <= 1'b1;
         phyInfoAddr <= phyReqAddr;
         phyInfoData <= regs[phyReqAddr];
      end
   end else if (phyReqValid) begin
      if (cnt >= waitCycles) phyReqReady <= 1'b1;
      cnt <= cnt + 4'h1;
   end
end
endmodule // lpa_phy_model
`default_nettype wire

// ---- sim/link_phy_access_and_fifo_status_tb_top.sv ----
// self-checking bench for the phy access and fifo status bank
`timescale 1ns/1ps
`default_nettype none
module link_phy_access_and_fifo_status_tb_top;
logic mclk, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, irqClear = 0, asyncFull = 1, asyncEmpty = 0;
logic isoFull = 0, isoEmpty = 1, rxEmpty = 1, rxTokenAtHead = 1, rxLastBlock = 0, triggerSplitEnable = 1;
logic flushBadPackets = 0, asyncFifoWriteReq = 1, isoFifoWriteReq = 1;
logic [7:0] paddr = '0;
logic [31:0] pwdata = '0, rd;
logic [8:0] asyncFreeSpace = 9'h1AB, isoFreeSpace = 9'h0C3, rxNextBlockQuadlets = 9'h111;
logic [8:0] asyncAllocSize = 9'd100, isoAllocSize = 9'd50;
logic [9:0] rxTotalQuadlets = 10'h2A5;
logic [3:0] waitCycles = 0;
wire [31:0] prdata;
wire [3:0] phyReqAddr, phyInfoAddr;
wire [7:0] phyReqData, phyInfoData;
wire pready, pslverr, phyReqValid, phyReqWrite, phyReqReady, phyInfoValid, phyInfoReceivedIrq;
wire asyncFifoWriteEn, isoFifoWriteEn, fifoDisabled;
int numErrors = 0, testsRun = 0;
lpa_phy_fifo_regs u_dut (.*);
lpa_phy_model u_phy (.*);
task chk(input logic [31:0] seen, exp, input string nm);
   testsRun++;
   if (seen !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
   end
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
   int n;
   @(posedge mclk);
   psel <= 1;
   pwrite <= w;
   paddr <= a;
   pwdata <= d;
   @(posedge mclk) penable <= 1;
   n = 0;
   do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 20);
   if (pready !== 1'b1) numErrors++;
   rd = prdata;
   psel <= 0;
   penable <= 0;
endtask
task phyIdle;
   int n;
   n = 0;
   do begin apb(0, 8'h24, '0); n++; end while (rd[31:30] !== 2'b00 && n < 30);
   if (rd[31:30] !== 2'b00) numErrors++;
endtask
task testDone;
   $display("checks %0d mismatches %0d", testsRun, numErrors);
   if (numErrors == 0 && testsRun > 0) $display("Test passed");
   else $display("Test failed");
   $finish;
endtask
initial begin
   mclk = 0;
   forever #5 mclk = ~mclk;
end
initial begin
   repeat (20000) @(posedge mclk);
   numErrors++;
   testDone;
end
initial begin
   repeat (6) @(posedge mclk);
   sys_rst <= 0;
   apb(0, 8'h24, '0); chk(rd, '0, "phy reset");
   apb(0, 8'h30, '0); chk(rd, 32'h8000_01AB, "async status");
   apb(1, 8'h34, '1); apb(0, 8'h34, '0); chk(rd, 32'h4000_00C3, "iso status");
   apb(0, 8'h3C, '0); chk(rd, 32'hD52A_D511, "rx status");
   flushBadPackets <= 1;
   apb(0, 8'h3C, '0); chk(rd, 32'hF52A_D511, "rx single block");
   asyncAllocSize <= '0;
   isoAllocSize <= '0;
   apb(0, 8'h3C, '0); chk(rd, 32'hF52C_0111, "rx full capacity");
   apb(0, 8'h40, '0); chk(rd, '0, "unmapped");
   chk(pslverr, 0, "slave error");
   chk({asyncFifoWriteEn, isoFifoWriteEn}, 2'b01, "fifo gates");
   apb(1, 8'h24, 32'h45A5_0000); phyIdle; chk(rd, 32'h05A5_0000, "phy write");
   waitCycles <= 3;
   apb(1, 8'h24, 32'h85A5_0000); phyIdle; chk(rd, 32'h05A5_05A5, "phy read");
   chk(phyInfoReceivedIrq, 1, "irq");
   irqClear <= 1;
   @(posedge mclk) irqClear <= 0;
   @(negedge mclk) chk(phyInfoReceivedIrq, 0, "irq clear");
   @(posedge mclk);
   asyncFull <= 0;
   asyncEmpty <= 1;
   asyncFreeSpace <= '0;
   apb(1, 8'h30, 32'h1C00_0000);
   @(negedge mclk) chk({fifoDisabled, asyncFifoWriteEn, isoFifoWriteEn}, 3'b100, "test gates");
   for (int i = 0; i < 3; i++) apb(1, 8'h80, 32'hA000_0000 + i);
   apb(0, 8'h30, '0); chk(rd, 32'h4C06_0000, "counter");
   apb(1, 8'h30, 32'h1C00_0000);
   for (int i = 0; i < 3; i++) begin
      apb(0, 8'h80, '0); chk(rd, 32'hA000_0000 + i, "ram word");
   end
   apb(1, 8'h30, 32'h1400_0000); apb(0, 8'h80, '0);
   apb(0, 8'h30, '0); chk(rd, 32'h6402_0000, "ctrl error");
   apb(1, 8'h30, '0); apb(0, 8'h30, '0); chk(rd[29], 0, "error cleared");
   testDone;
end
endmodule // link_phy_access_and_fifo_status_tb_top
`default_nettype wire
